// file: hdl/qdsc_top.sv
// Encoder input status, event flags and position, speed and marker counters
//
// Contract
// - Reference status bit is the synced reference pin, inverted when its invert bit set.
// - Marker status bit is the synced marker pin, optionally inverted; read-only.
// - Phase B status takes pin B, or pin A when swapped, then optional inversion.
// - Phase A status takes pin A, or pin B when swapped, then optional inversion.
// - Upper compare flag sets while position is at or above upper compare value.
// - Lower compare flag sets while position is at or below lower compare value.
// - Marker event flag sets on a marker event and stays until cleared.
// - Marker flag requests an event only while its enable is one.
// - Reference event flag sets on a reference event; enable gates its request.
// - Homing flag sets on homing reinit only in position init modes 011 and 100.
// - Position count is 32 bits in two readable writable words, reset to zero.
// - Position high hold register buffers the high word for reads and writes.
// - Reading position low copies the high word into the hold register.
// - Writing position low loads hold into high word in the same cycle.
// - Position wrap flag sets on crossing between 7FFFFFFF and 80000000.
// - Speed count is 16 bits, read write; its wrap sets the speed wrap flag.
// - Marker count is 32 bits in two readable writable words, reset to zero.
// - Marker high hold register works like the position hold register.
// - Init capture high register holds bits 31 to 16, read write, reset zero.
`timescale 1ns/100ps
`default_nettype none
module qdsc_top (
    // Clock and reset
    input wire logic mclk,
    input wire logic srst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [qdsc_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Encoder pins
    input wire logic phase_a_line,
    input wire logic phase_b_line,
    input wire logic revolution_marker_pin,
    input wire logic reference_switch_pin,
    // Decoder side, same clock
    input wire logic count_up,
    input wire logic count_down,
    input wire logic homing_reinit,
    input wire logic [2:0] position_init_select,
    input wire logic [31:0] upper_compare_value,
    input wire logic [31:0] lower_compare_value,
    // Outputs
    output logic phase_a_out,
    output logic phase_b_out,
    output logic event_request,
    output logic [15:0] init_capture_high
);
    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    logic [3:0] pin_s;
    logic [15:0] ioc_q;
    logic [15:0] stat_q;
    logic [15:0] speed_count_q;
    logic [31:0] position_count;
    logic [15:0] position_high_hold;
    logic [31:0] marker_count;
    logic [15:0] marker_high_hold;
    logic phase_a_dec;
    logic phase_b_dec;
    logic marker_lvl;
    logic reference_lvl;
    logic marker_prev_q;
    logic reference_prev_q;
    logic marker_evt;
    logic reference_evt;
    logic [3:0] line_status;
    qdsc_pkg::qdsc_sel_t sel;
    logic sample;
    logic commit;
    logic [1:0] strb;
    logic wr_ioc, wr_stat, wr_pos_low, wr_pos_high, wr_pos_hold;
    logic wr_speed, wr_mrk_low, wr_mrk_high, wr_mrk_hold, wr_ich;
    logic snap_pos, snap_mrk;
    logic pos_wrap, spd_wrap, homing_ok;
    logic [15:0] set_vec;
    logic [15:0] clr_vec;
    logic [15:0] rd_word;
    logic step_up, step_dn;

    // ----------------------------------------
    // Address decode
    // ----------------------------------------
    function automatic qdsc_pkg::qdsc_sel_t decode(input logic [qdsc_pkg::ADDR_W-1:0] a);
        if (a == qdsc_pkg::OFS_INPUT_LINE_CONTROL) begin
            return qdsc_pkg::SEL_IOC;
        end else if (a == qdsc_pkg::OFS_EVENT_STATUS_ENABLE) begin
            return qdsc_pkg::SEL_STAT;
        end else if (a == qdsc_pkg::OFS_POSITION_COUNT_LOW) begin
            return qdsc_pkg::SEL_POS_LOW;
        end else if (a == qdsc_pkg::OFS_POSITION_COUNT_HIGH) begin
            return qdsc_pkg::SEL_POS_HIGH;
        end else if (a == qdsc_pkg::OFS_POSITION_HIGH_HOLD) begin
            return qdsc_pkg::SEL_POS_HOLD;
        end else if (a == qdsc_pkg::OFS_SPEED_COUNT) begin
            return qdsc_pkg::SEL_SPEED;
        end else if (a == qdsc_pkg::OFS_MARKER_COUNT_LOW) begin
            return qdsc_pkg::SEL_MRK_LOW;
        end else if (a == qdsc_pkg::OFS_MARKER_COUNT_HIGH) begin
            return qdsc_pkg::SEL_MRK_HIGH;
        end else if (a == qdsc_pkg::OFS_MARKER_HIGH_HOLD) begin
            return qdsc_pkg::SEL_MRK_HOLD;
        end else if (a == qdsc_pkg::OFS_INIT_CAPTURE_HIGH) begin
            return qdsc_pkg::SEL_ICH;
        end else begin
            return qdsc_pkg::SEL_NONE;
        end
    endfunction : decode

    // ----------------------------------------
    // Pin synchronisation and line status
    // ----------------------------------------
    qdsc_sync #(.W(4)) u_sync (
        .mclk(mclk),
        .srst(srst),
        .async_in({reference_switch_pin, revolution_marker_pin, phase_b_line, phase_a_line}),
        .sync_out(pin_s)
    );

    assign phase_a_dec = (ioc_q[qdsc_pkg::IOC_SWAP] ? pin_s[1] : pin_s[0])
                         ^ ioc_q[qdsc_pkg::IOC_A_INV];
    assign phase_b_dec = (ioc_q[qdsc_pkg::IOC_SWAP] ? pin_s[0] : pin_s[1])
                         ^ ioc_q[qdsc_pkg::IOC_B_INV];
    assign marker_lvl = pin_s[2] ^ ioc_q[qdsc_pkg::IOC_MRK_INV];
    assign reference_lvl = pin_s[3] ^ ioc_q[qdsc_pkg::IOC_REF_INV];
    assign line_status = {reference_lvl, marker_lvl, phase_b_dec, phase_a_dec};
    assign marker_evt = marker_lvl && !marker_prev_q;
    assign reference_evt = reference_lvl && !reference_prev_q;

    always_ff @(posedge mclk) begin
        if (srst) begin
            marker_prev_q <= 1'b0;
            reference_prev_q <= 1'b0;
            phase_a_out <= 1'b0;
            phase_b_out <= 1'b0;
        end else begin
            marker_prev_q <= marker_lvl;
            reference_prev_q <= reference_lvl;
            phase_a_out <= phase_a_dec;
            phase_b_out <= phase_b_dec;
        end
    end

    // ----------------------------------------
    // APB handshake
    // ----------------------------------------
    assign sel = decode(paddr);
    assign sample = psel && penable && !pready;
    assign commit = psel && penable && pready;
    assign strb = pstrb[1:0];
    assign wr_ioc = commit && pwrite && (sel == qdsc_pkg::SEL_IOC);
    assign wr_stat = commit && pwrite && (sel == qdsc_pkg::SEL_STAT);
    assign wr_pos_low = commit && pwrite && (sel == qdsc_pkg::SEL_POS_LOW);
    assign wr_pos_high = commit && pwrite && (sel == qdsc_pkg::SEL_POS_HIGH);
    assign wr_pos_hold = commit && pwrite && (sel == qdsc_pkg::SEL_POS_HOLD);
    assign wr_speed = commit && pwrite && (sel == qdsc_pkg::SEL_SPEED);
    assign wr_mrk_low = commit && pwrite && (sel == qdsc_pkg::SEL_MRK_LOW);
    assign wr_mrk_high = commit && pwrite && (sel == qdsc_pkg::SEL_MRK_HIGH);
    assign wr_mrk_hold = commit && pwrite && (sel == qdsc_pkg::SEL_MRK_HOLD);
    assign wr_ich = commit && pwrite && (sel == qdsc_pkg::SEL_ICH);
    assign snap_pos = sample && !pwrite && (sel == qdsc_pkg::SEL_POS_LOW);
    assign snap_mrk = sample && !pwrite && (sel == qdsc_pkg::SEL_MRK_LOW);

    always_comb begin
        case (sel)
            qdsc_pkg::SEL_IOC: rd_word = {ioc_q[15:4], line_status};
            qdsc_pkg::SEL_STAT: rd_word = stat_q;
            qdsc_pkg::SEL_POS_LOW: rd_word = position_count[15:0];
            qdsc_pkg::SEL_POS_HIGH: rd_word = position_count[31:16];
            qdsc_pkg::SEL_POS_HOLD: rd_word = position_high_hold;
            qdsc_pkg::SEL_SPEED: rd_word = speed_count_q;
            qdsc_pkg::SEL_MRK_LOW: rd_word = marker_count[15:0];
            qdsc_pkg::SEL_MRK_HIGH: rd_word = marker_count[31:16];
            qdsc_pkg::SEL_MRK_HOLD: rd_word = marker_high_hold;
            qdsc_pkg::SEL_ICH: rd_word = init_capture_high;
            default: rd_word = qdsc_pkg::RST_WORD;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= qdsc_pkg::RST_DWORD;
        end else if (sample) begin
            pready <= 1'b1;
            pslverr <= (sel == qdsc_pkg::SEL_NONE);
            prdata <= pwrite ? qdsc_pkg::RST_DWORD : {16'h0000, rd_word};
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // ----------------------------------------
    // Control registers
    // ----------------------------------------
    always_ff @(posedge mclk) begin
        if (srst) begin
            ioc_q <= qdsc_pkg::RST_WORD;
        end else if (wr_ioc) begin
            ioc_q <= qdsc_pkg::merge16(ioc_q, pwdata[15:0], strb) & qdsc_pkg::IOC_WR_MASK;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            init_capture_high <= qdsc_pkg::RST_WORD;
        end else if (wr_ich) begin
            init_capture_high <= qdsc_pkg::merge16(init_capture_high, pwdata[15:0], strb);
        end
    end

    // ----------------------------------------
    // Counters
    // ----------------------------------------
    assign step_up = count_up && !count_down;
    assign step_dn = count_down && !count_up;

    qdsc_count_pair u_position (
        .mclk(mclk),
        .srst(srst),
        .count_up(count_up),
        .count_down(count_down),
        .rd_snap(snap_pos),
        .wr_low(wr_pos_low),
        .wr_high(wr_pos_high),
        .wr_hold(wr_pos_hold),
        .wr_data(pwdata[15:0]),
        .wr_strb(strb),
        .count_q(position_count),
        .hold_q(position_high_hold)
    );

    qdsc_count_pair u_marker (
        .mclk(mclk),
        .srst(srst),
        .count_up(marker_evt),
        .count_down(1'b0),
        .rd_snap(snap_mrk),
        .wr_low(wr_mrk_low),
        .wr_high(wr_mrk_high),
        .wr_hold(wr_mrk_hold),
        .wr_data(pwdata[15:0]),
        .wr_strb(strb),
        .count_q(marker_count),
        .hold_q(marker_high_hold)
    );

    always_ff @(posedge mclk) begin
        if (srst) begin
            speed_count_q <= qdsc_pkg::RST_WORD;
        end else if (wr_speed) begin
            speed_count_q <= qdsc_pkg::merge16(speed_count_q, pwdata[15:0], strb);
        end else if (step_up) begin
            speed_count_q <= speed_count_q + 16'h0001;
        end else if (step_dn) begin
            speed_count_q <= speed_count_q - 16'h0001;
        end
    end

    // ----------------------------------------
    // Event flags and request
    // ----------------------------------------
    assign pos_wrap = !wr_pos_low && !wr_pos_high
                      && ((step_up && position_count == qdsc_pkg::POS_WRAP_LO)
                      || (step_dn && position_count == qdsc_pkg::POS_WRAP_HI));
    assign spd_wrap = !wr_speed && ((step_up && speed_count_q == qdsc_pkg::SPD_WRAP_LO)
                      || (step_dn && speed_count_q == qdsc_pkg::SPD_WRAP_HI));
    assign homing_ok = homing_reinit && (position_init_select == qdsc_pkg::PI_HOME_A
                       || position_init_select == qdsc_pkg::PI_HOME_B);

    always_comb begin
        set_vec = qdsc_pkg::RST_WORD;
        set_vec[qdsc_pkg::ST_UPPER_F] = $signed(position_count) >= $signed(upper_compare_value);
        set_vec[qdsc_pkg::ST_LOWER_F] = $signed(position_count) <= $signed(lower_compare_value);
        set_vec[qdsc_pkg::ST_POSW_F] = pos_wrap;
        set_vec[qdsc_pkg::ST_HOME_F] = homing_ok;
        set_vec[qdsc_pkg::ST_SPDW_F] = spd_wrap;
        set_vec[qdsc_pkg::ST_REF_F] = reference_evt;
        set_vec[qdsc_pkg::ST_MRK_F] = marker_evt;
        clr_vec = qdsc_pkg::RST_WORD;
        if (wr_stat) begin
            clr_vec = qdsc_pkg::ST_FLAG_MASK & ~qdsc_pkg::merge16(16'hFFFF, pwdata[15:0],
                      strb);
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            stat_q <= qdsc_pkg::RST_WORD;
        end else begin
            stat_q <= (((stat_q & qdsc_pkg::ST_FLAG_MASK) & ~clr_vec) | set_vec)
                      | ((wr_stat ? qdsc_pkg::merge16(stat_q, pwdata[15:0], strb) : stat_q)
                      & qdsc_pkg::ST_EN_MASK);
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            event_request <= 1'b0;
        end else begin
            event_request <= |(stat_q[13:0] & {stat_q[12:0], 1'b0} & qdsc_pkg::ST_FLAG_MASK[13:0]);
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);

    ref_status_rd_a: assert property (sample && !pwrite && sel == qdsc_pkg::SEL_IOC |=>
        prdata[3] == $past(pin_s[3] ^ ioc_q[qdsc_pkg::IOC_REF_INV]))
        else $error("reference status bit wrong");
    phase_swap_a: assert property (##1 phase_a_out == $past(ioc_q[qdsc_pkg::IOC_SWAP] ?
        pin_s[1] ^ ioc_q[qdsc_pkg::IOC_A_INV] : pin_s[0] ^ ioc_q[qdsc_pkg::IOC_A_INV]))
        else $error("phase a swap or invert wrong");
    marker_flag_a: assert property (marker_evt |=> stat_q[qdsc_pkg::ST_MRK_F])
        else $error("marker event not flagged");
    flag_sticky_a: assert property (stat_q[qdsc_pkg::ST_REF_F] && !wr_stat
        |=> stat_q[qdsc_pkg::ST_REF_F])
        else $error("reference flag lost without clear");
    upper_cmp_a: assert property ($signed(position_count) >= $signed(upper_compare_value)
        |=> stat_q[qdsc_pkg::ST_UPPER_F])
        else $error("upper compare flag not set");
    lower_cmp_a: assert property ($signed(position_count) <= $signed(lower_compare_value)
        |=> stat_q[qdsc_pkg::ST_LOWER_F])
        else $error("lower compare flag not set");
    pos_wrap_a: assert property (step_up && position_count == qdsc_pkg::POS_WRAP_LO
        && !wr_pos_low && !wr_pos_high |=> stat_q[qdsc_pkg::ST_POSW_F]
        && position_count == qdsc_pkg::POS_WRAP_HI)
        else $error("position wrap not flagged");
    hold_snap_a: assert property (snap_pos ##1 pready |->
        position_high_hold == $past(position_count[31:16]))
        else $error("hold not loaded on low read");
    low_load_a: assert property (wr_pos_low && strb == 2'h3 |=>
        position_count == {$past(position_high_hold), $past(pwdata[15:0])})
        else $error("low write did not load both words");
    req_gate_a: assert property (stat_q[qdsc_pkg::ST_MRK_F] && !stat_q[qdsc_pkg::ST_MRK_E]
        && (stat_q & {stat_q[14:0], 1'b0} & qdsc_pkg::ST_FLAG_MASK) == 16'h0000
        |=> !event_request)
        else $error("request raised while disabled");
    homing_mode_a: assert property (homing_reinit && !homing_ok
        && !stat_q[qdsc_pkg::ST_HOME_F] |=> !stat_q[qdsc_pkg::ST_HOME_F])
        else $error("homing flag set in wrong mode");
    one_no_set_a: assert property (wr_stat && !set_vec[qdsc_pkg::ST_MRK_F]
        && !stat_q[qdsc_pkg::ST_MRK_F] |=> !stat_q[qdsc_pkg::ST_MRK_F])
        else $error("write of one set a flag");

    cov_marker_c: cover property (marker_evt ##1 stat_q[qdsc_pkg::ST_MRK_F] ##[1:20] wr_stat);
    cov_coherent_c: cover property (snap_pos ##[1:10] sample && sel == qdsc_pkg::SEL_POS_HOLD);
    cov_wrap_c: cover property (pos_wrap ##1 event_request);
endmodule : qdsc_top
`default_nettype wire

// file: hdl/qdsc_pkg.sv
// Constants, register map and helpers of the encoder status and counter block
package qdsc_pkg;

    // ----------------------------------------
    // Bus geometry
    // ----------------------------------------
    localparam int ADDR_W = 8;

    // ----------------------------------------
    // Register byte offsets
    // ----------------------------------------
    localparam logic [7:0] OFS_INPUT_LINE_CONTROL = 8'h00;
    localparam logic [7:0] OFS_EVENT_STATUS_ENABLE = 8'h04;
    localparam logic [7:0] OFS_POSITION_COUNT_LOW = 8'h08;
    localparam logic [7:0] OFS_POSITION_COUNT_HIGH = 8'h0C;
    localparam logic [7:0] OFS_POSITION_HIGH_HOLD = 8'h10;
    localparam logic [7:0] OFS_SPEED_COUNT = 8'h14;
    localparam logic [7:0] OFS_MARKER_COUNT_LOW = 8'h18;
    localparam logic [7:0] OFS_MARKER_COUNT_HIGH = 8'h1C;
    localparam logic [7:0] OFS_MARKER_HIGH_HOLD = 8'h20;
    localparam logic [7:0] OFS_INIT_CAPTURE_HIGH = 8'h24;

    // ----------------------------------------
    // Register selectors
    // ----------------------------------------
    typedef enum logic [3:0] {
        SEL_IOC = 4'h0,
        SEL_STAT = 4'h1,
        SEL_POS_LOW = 4'h2,
        SEL_POS_HIGH = 4'h3,
        SEL_POS_HOLD = 4'h4,
        SEL_SPEED = 4'h5,
        SEL_MRK_LOW = 4'h6,
        SEL_MRK_HIGH = 4'h7,
        SEL_MRK_HOLD = 4'h8,
        SEL_ICH = 4'h9,
        SEL_NONE = 4'hF
    } qdsc_sel_t;

    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int IOC_SWAP = 8;
    localparam int IOC_REF_INV = 7;
    localparam int IOC_MRK_INV = 6;
    localparam int IOC_B_INV = 5;
    localparam int IOC_A_INV = 4;
    localparam logic [15:0] IOC_WR_MASK = 16'hFFF0;
    localparam int ST_UPPER_F = 13;
    localparam int ST_UPPER_E = 12;
    localparam int ST_LOWER_F = 11;
    localparam int ST_LOWER_E = 10;
    localparam int ST_POSW_F = 9;
    localparam int ST_POSW_E = 8;
    localparam int ST_HOME_F = 7;
    localparam int ST_HOME_E = 6;
    localparam int ST_SPDW_F = 5;
    localparam int ST_SPDW_E = 4;
    localparam int ST_REF_F = 3;
    localparam int ST_REF_E = 2;
    localparam int ST_MRK_F = 1;
    localparam int ST_MRK_E = 0;
    localparam logic [15:0] ST_FLAG_MASK = 16'h2AAA;
    localparam logic [15:0] ST_EN_MASK = 16'h1555;

    // ----------------------------------------
    // Reset values and special counts
    // ----------------------------------------
    localparam logic [15:0] RST_WORD = 16'h0000;
    localparam logic [31:0] RST_DWORD = 32'h0000_0000;
    localparam logic [2:0] PI_HOME_A = 3'h3;
    localparam logic [2:0] PI_HOME_B = 3'h4;
    localparam logic [31:0] POS_WRAP_LO = 32'h7FFF_FFFF;
    localparam logic [31:0] POS_WRAP_HI = 32'h8000_0000;
    localparam logic [15:0] SPD_WRAP_LO = 16'h7FFF;
    localparam logic [15:0] SPD_WRAP_HI = 16'h8000;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [15:0] merge16(input logic [15:0] old_v, input logic [15:0] new_v,
                                            input logic [1:0] strb);
        logic [15:0] m;
        m = {{8{strb[1]}}, {8{strb[0]}}};
        return (old_v & ~m) | (new_v & m);
    endfunction : merge16

endpackage : qdsc_pkg

// file: hdl/qdsc_sync.sv
// Two-stage synchroniser for asynchronous pin levels
`timescale 1ns/100ps
`default_nettype none
module qdsc_sync #(
    parameter int W = 4
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic srst,
    // Levels
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] meta_q;

    always_ff @(posedge mclk) begin
        if (srst) begin
            meta_q <= '0;
            sync_out <= '0;
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule : qdsc_sync
`default_nettype wire

// file: hdl/qdsc_count_pair.sv
// 32-bit counter split in two words with a high-word hold register
`timescale 1ns/100ps
`default_nettype none
module qdsc_count_pair (
    // Clock and reset
    input wire logic mclk,
    input wire logic srst,
    // Counting
    input wire logic count_up,
    input wire logic count_down,
    // Software access
    input wire logic rd_snap,
    input wire logic wr_low,
    input wire logic wr_high,
    input wire logic wr_hold,
    input wire logic [15:0] wr_data,
    input wire logic [1:0] wr_strb,
    // State
    output logic [31:0] count_q,
    output logic [15:0] hold_q
);
    always_ff @(posedge mclk) begin
        if (srst) begin
            count_q <= qdsc_pkg::RST_DWORD;
        end else if (wr_low) begin
            count_q <= {hold_q, qdsc_pkg::merge16(count_q[15:0], wr_data, wr_strb)};
        end else if (wr_high) begin
            count_q[31:16] <= qdsc_pkg::merge16(count_q[31:16], wr_data, wr_strb);
        end else if (count_up && !count_down) begin
            count_q <= count_q + 32'h0000_0001;
        end else if (count_down && !count_up) begin
            count_q <= count_q - 32'h0000_0001;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            hold_q <= qdsc_pkg::RST_WORD;
        end else if (wr_hold) begin
            hold_q <= qdsc_pkg::merge16(hold_q, wr_data, wr_strb);
        end else if (rd_snap) begin
            hold_q <= count_q[31:16];
        end
    end
endmodule : qdsc_count_pair
`default_nettype wire

// file: testbench/qdsc_enc_model.sv
// Incremental encoder model driving phase, marker and reference pins
`timescale 1ns/100ps
`default_nettype none
module qdsc_enc_model (
    // Encoder pins
    output logic phase_a,
    output logic phase_b,
    output logic marker,
    output logic ref_sw
);
    // ----------------------------------------
    // Pin levels, static between moves
    // ----------------------------------------
    task automatic put(input logic [3:0] v);
        {ref_sw, marker, phase_b, phase_a} <= v;
    endtask : put
    initial put(4'h0);
endmodule : qdsc_enc_model
`default_nettype wire

// file: testbench/qdsc_top_tb.sv
// Self-checking bench of the encoder status and counter block
`timescale 1ns/100ps
`default_nettype none
module qdsc_top_tb;
    // ----------------------------------------
    // Signals, model and design
    // ----------------------------------------
    logic mclk, srst, psel, penable, pwrite, cup, cdn, hom, err, pa, pb, mk, rf, ao, bo, evr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, upv, lov, r;
    logic [2:0] pis;
    logic [15:0] ich;
    logic pready, pslverr;
    int fails = 0;
    int num_checks = 0;
    qdsc_enc_model i_qdsc_enc_model (.phase_a(pa), .phase_b(pb), .marker(mk), .ref_sw(rf));
    qdsc_top i_qdsc_top (.mclk(mclk), .srst(srst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'h3), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .phase_a_line(pa), .phase_b_line(pb),
        .revolution_marker_pin(mk), .reference_switch_pin(rf), .count_up(cup),
        .count_down(cdn), .homing_reinit(hom), .position_init_select(pis),
        .upper_compare_value(upv), .lower_compare_value(lov), .phase_a_out(ao),
        .phase_b_out(bo), .event_request(evr), .init_capture_high(ich));
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    task tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : tally_and_finish
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    // ----------------------------------------
    // APB master cycle
    // ----------------------------------------
    task automatic xfer(input logic w, input logic [7:0] a, input logic [15:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {16'h0000, d};
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            fails++;
            tally_and_finish;
        end
        r = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask : xfer
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 16'h0000);
        chk("read data", r, exp);
    endtask : rd
    task automatic step(input logic dn);
        cup <= !dn;
        cdn <= dn;
        @(posedge mclk);
        cup <= 1'b0;
        cdn <= 1'b0;
        @(posedge mclk);
    endtask : step
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        {srst, psel, penable, pwrite, cup, cdn, hom} = 7'h40;
        paddr = 8'h00;
        pwdata = 32'h0;
        pis = 3'h0;
        upv = 32'h7FFF_FFFF;
        lov = 32'h8000_0000;
        repeat (5) @(posedge mclk);
        srst <= 1'b0;
        @(posedge mclk);
        for (int i = 0; i < 10; i++) rd(8'(4 * i), 32'h0);
        rd(8'h40, 32'h0);
        chk("unmapped error", {31'h0, err}, 32'h1);
        i_qdsc_enc_model.put(4'h1);
        repeat (4) @(posedge mclk);
        rd(8'h00, 32'h0001);
        chk("phase a out", {31'h0, ao}, 32'h1);
        xfer(1'b1, 8'h00, 16'h0100);
        rd(8'h00, 32'h0102);
        chk("phase b out", {31'h0, bo}, 32'h1);
        xfer(1'b1, 8'h00, 16'h0110);
        rd(8'h00, 32'h0113);
        xfer(1'b1, 8'h00, 16'h00C0);
        rd(8'h00, 32'h00CD);
        rd(8'h04, 32'h000A);
        rd(8'h18, 32'h0001);
        xfer(1'b1, 8'h04, 16'h000B);
        rd(8'h04, 32'h000B);
        chk("event request", {31'h0, evr}, 32'h1);
        xfer(1'b1, 8'h04, 16'h0000);
        rd(8'h04, 32'h0000);
        chk("event request", {31'h0, evr}, 32'h0);
        xfer(1'b1, 8'h10, 16'h7FFF);
        xfer(1'b1, 8'h08, 16'hFFFF);
        rd(8'h0C, 32'h7FFF);
        step(1'b0);
        rd(8'h08, 32'h0000);
        rd(8'h10, 32'h8000);
        rd(8'h04, 32'h2A00);
        rd(8'h14, 32'h0001);
        xfer(1'b1, 8'h04, 16'h0000);
        rd(8'h04, 32'h0800);
        pis <= 3'h3;
        hom <= 1'b1;
        @(posedge mclk);
        hom <= 1'b0;
        @(posedge mclk);
        rd(8'h04, 32'h0880);
        step(1'b1);
        rd(8'h04, 32'h2A80);
        rd(8'h14, 32'h0000);
        xfer(1'b1, 8'h14, 16'h7FFF);
        step(1'b0);
        rd(8'h14, 32'h8000);
        rd(8'h04, 32'h2AA0);
        xfer(1'b1, 8'h20, 16'h1234);
        xfer(1'b1, 8'h18, 16'h5678);
        rd(8'h1C, 32'h1234);
        xfer(1'b1, 8'h24, 16'hBEEF);
        rd(8'h24, 32'hBEEF);
        chk("capture high", {16'h0, ich}, 32'hBEEF);
        tally_and_finish;
    end
endmodule : qdsc_top_tb
`default_nettype wire
